// [logic/pief_defines.svh]
// pief_defines.svh: offsets, field positions and reset values of the
// port input and external interrupt flag block.
// assumes: included by its bare name from the package and the design file.
`ifndef PIEF_DEFINES_SVH
`define PIEF_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define PIEF_IDX_PORT0        8'h02
`define PIEF_IDX_PORT1        8'h03
`define PIEF_IDX_FLAGS_LOW    8'h04
`define PIEF_IDX_EN_LOW       8'h05
`define PIEF_IDX_FLAGS_HIGH   8'h06
`define PIEF_IDX_EN_HIGH      8'h07
`define PIEF_IDX_POLARITY     8'h0A
`define PIEF_IDX_LATCH        8'h0B
`define PIEF_IDX_IRQ_MASK     8'h0C

// field layout
`define PIEF_PORT1_MSB        3'h6
`define PIEF_HIGH_SRC_CNT     3'h4

// reset values
`define PIEF_FLAGS_RST        8'h00
`define PIEF_EN_RST           8'h00
`define PIEF_POL_RST          12'h000
`define PIEF_LATCH_RST        15'h7FFF
`define PIEF_MASK_RST         1'h1

`endif

// [logic/pief_pkg.sv]
// pief_pkg.sv: types of the port input and external interrupt flag block.
// assumes: pief_defines.svh sits beside it.
`include "pief_defines.svh"
package pief_pkg;
	// full register state of the block
	typedef struct packed {
		logic [7:0]  p0_s1;      // pin sync stage 1
		logic [7:0]  p0_s2;      // pin sync stage 2
		logic [7:0]  p0_s3;      // pin sync stage 3
		logic [6:0]  p1_s1;
		logic [6:0]  p1_s2;
		logic [6:0]  p1_s3;
		logic [7:0]  p0_lvl;     // debounced port 0 level
		logic [6:0]  p1_lvl;     // debounced port 1 level
		logic [11:0] x_s1;       // interrupt pin sync
		logic [11:0] x_s2;
		logic [11:0] x_s3;
		logic [11:0] x_lvl;      // accepted interrupt pin level
		logic        x_valid;    // x_lvl holds a real sample
		logic [11:0] flags;      // edge detect flags
		logic [11:0] enables;    // source enables
		logic [11:0] polarity;   // edge polarity selects
		logic [14:0] latch;      // output latch bits, pullup control
		logic        mask;       // global interrupt mask
		logic        irq;        // interrupt request
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} pief_state_type;
endpackage : pief_pkg

// [logic/pief_top.sv]
// pief_top.sv: port input registers and external interrupt flags on APB.
// assumes: one 100 MHz clock, synchronous active-high reset, pins
// asynchronous to the clock, an APB master with 32-bit data.
`timescale 1ns/1ps
`default_nettype none
`include "pief_defines.svh"

module pief_top (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	input  wire logic [7:0]  port0_pins_i,
	input  wire logic [6:0]  port1_pins_i,
	input  wire logic [11:0] ext_int_pins_i,
	output logic [14:0]      pullup_en_o,
	output logic             irq_o
);

	// the whole state and its next value
	pief_pkg::pief_state_type st_r;
	pief_pkg::pief_state_type st_nxt;

	// bus decode helpers
	logic       acc_w;     // access phase of a transfer
	logic [7:0] idx_w;     // register index from byte address
	logic       aligned_w; // low address bits clear, index in range
	assign acc_w     = psel_i & penable_i;
	assign idx_w     = paddr_i[9:2];
	assign aligned_w = (paddr_i[1:0] == 2'h0) & (paddr_i[11:10] == 2'h0);

	// how the pieces fit together:
	//   every pin, port or interrupt, runs through three flops; stage 1 is
	//   the metastability catcher and nothing but stage 2 reads it.
	//   a new level is accepted only when stages 2 and 3 agree, which
	//   filters single-clock glitches at the cost of two clocks of latency.
	//   the accepted level of a port pin is what software reads back, so
	//   the pin registers always show the filtered live state.
	//   the accepted level of an interrupt pin is compared with its last
	//   accepted level; a change in the chosen direction sets the flag.
	//   x_valid blocks the very first comparison after reset, because the
	//   stored level then still holds whatever the pin had during reset.
	// hazards:
	//   a flag write and a pin edge may land in one clock; the edge wins,
	//   otherwise an event arriving during the clear would be lost forever.
	//   a write with the polarity bit changing may itself look like an
	//   edge to software; the hardware only uses the polarity it already
	//   held when the edge was accepted.
	//   the sync chain keeps running in reset so the pin registers are
	//   valid as soon as reset drops, which the pin registers need since
	//   their reset value is the pin state, not a constant.
	// trade-offs:
	//   all bus answers are registered, costing one wait state per
	//   transfer but keeping every output straight from a flop.
	//   the request is registered too, so it trails the flag change by
	//   nothing: both come from the same next-state value.
	//   the global mask is an extra gate beside the per-source enables;
	//   it resets to one so that the enables alone decide after reset.
	// limitations:
	//   pulses shorter than two clocks may be missed on any pin.
	//   pin direction is not known here; pullups follow the latch bits
	//   alone, and the outer logic must qualify them with direction.
	//   only byte lane 0 carries the eight-bit registers; the wider
	//   polarity and latch registers need lanes 0 and 1 together.

	// next state: pins, edges, flags, bus
	always_comb begin
		logic [11:0] rise;
		logic [11:0] fall;
		logic [11:0] hit;
		logic [11:0] clr;
		logic        wr;
		logic        known;
		logic [31:0] rd;
		rise  = 12'h000;
		fall  = 12'h000;
		hit   = 12'h000;
		clr   = 12'h000;
		wr    = 1'b0;
		known = 1'b0;
		rd    = 32'h0000_0000;
		st_nxt = st_r;
		// three-stage pin sync; stage 1 feeds only stage 2
		st_nxt.p0_s1 = port0_pins_i;
		st_nxt.p0_s2 = st_r.p0_s1;
		st_nxt.p0_s3 = st_r.p0_s2;
		st_nxt.p1_s1 = port1_pins_i;
		st_nxt.p1_s2 = st_r.p1_s1;
		st_nxt.p1_s3 = st_r.p1_s2;
		st_nxt.x_s1  = ext_int_pins_i;
		st_nxt.x_s2  = st_r.x_s1;
		st_nxt.x_s3  = st_r.x_s2;
		// a level counts once stages 2 and 3 agree
		for (int i = 0; i < 8; i++) begin
			if (st_r.p0_s2[i] == st_r.p0_s3[i]) begin
				st_nxt.p0_lvl[i] = st_r.p0_s3[i];
			end
		end
		for (int i = 0; i < 7; i++) begin
			if (st_r.p1_s2[i] == st_r.p1_s3[i]) begin
				st_nxt.p1_lvl[i] = st_r.p1_s3[i];
			end
		end
		// edge detect; first accepted sample after reset sets no flag
		for (int i = 0; i < 12; i++) begin
			if (st_r.x_s2[i] == st_r.x_s3[i]) begin
				st_nxt.x_lvl[i] = st_r.x_s3[i];
				rise[i] = st_r.x_valid & ~st_r.x_lvl[i] & st_r.x_s3[i];
				fall[i] = st_r.x_valid & st_r.x_lvl[i] & ~st_r.x_s3[i];
			end
		end
		st_nxt.x_valid = 1'b1;
		hit = (fall & st_r.polarity) | (rise & ~st_r.polarity);
		// APB: one wait state, answer on second access cycle
		st_nxt.pready  = acc_w & ~st_r.pready;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata  = 32'h0000_0000;
		// misaligned writes must have no effect at all, so alignment gates here
		wr = acc_w & ~st_r.pready & pwrite_i & pstrb_i[0] & aligned_w;
		case (idx_w)
			`PIEF_IDX_PORT0: begin
				known = 1'b1;
				rd[7:0] = st_r.p0_lvl;
			end
			`PIEF_IDX_PORT1: begin
				known = 1'b1;
				rd[7:0] = {1'b0, st_r.p1_lvl};
			end
			`PIEF_IDX_FLAGS_LOW: begin
				known = 1'b1;
				rd[7:0] = st_r.flags[7:0];
				if (wr) begin
					clr[7:0] = ~pwdata_i[7:0] & st_r.flags[7:0];
					hit[7:0] = hit[7:0] | pwdata_i[7:0];
				end
			end
			`PIEF_IDX_EN_LOW: begin
				known = 1'b1;
				rd[7:0] = st_r.enables[7:0];
				if (wr) begin
					st_nxt.enables[7:0] = pwdata_i[7:0];
				end
			end
			`PIEF_IDX_FLAGS_HIGH: begin
				known = 1'b1;
				rd[7:0] = {4'h0, st_r.flags[11:8]};
				if (wr) begin
					clr[11:8] = ~pwdata_i[3:0] & st_r.flags[11:8];
					hit[11:8] = hit[11:8] | pwdata_i[3:0];
				end
			end
			`PIEF_IDX_EN_HIGH: begin
				known = 1'b1;
				rd[7:0] = {4'h0, st_r.enables[11:8]};
				if (wr) begin
					st_nxt.enables[11:8] = pwdata_i[3:0];
				end
			end
			`PIEF_IDX_POLARITY: begin
				known = 1'b1;
				rd[11:0] = st_r.polarity;
				if (wr & pstrb_i[1]) begin
					st_nxt.polarity = pwdata_i[11:0];
				end
			end
			`PIEF_IDX_LATCH: begin
				known = 1'b1;
				rd[14:0] = st_r.latch;
				if (wr & pstrb_i[1]) begin
					st_nxt.latch = pwdata_i[14:0];
				end
			end
			`PIEF_IDX_IRQ_MASK: begin
				known = 1'b1;
				rd[0] = st_r.mask;
				if (wr) begin
					st_nxt.mask = pwdata_i[0];
				end
			end
			default: begin
				known = 1'b0; // unmapped: error, reads zero
			end
		endcase
		known = known & aligned_w;
		if (acc_w & ~st_r.pready) begin
			st_nxt.prdata  = known ? rd : 32'h0000_0000;
			st_nxt.pslverr = ~known;
		end
		// sticky flags: set beats clear in the same cycle
		if (~known) begin
			clr = 12'h000;
		end
		st_nxt.flags = (st_r.flags & ~clr) | hit;
		// level request: any flag with its enable, gated by mask
		// next mask too, so a mask write and the request move together
		st_nxt.irq = st_nxt.mask & |(st_nxt.flags & st_nxt.enables);
		// reset loads control reset values, latch and mask to ones; sync chain keeps running
		if (reset_i) begin
			st_nxt.flags    = {4'h0, `PIEF_FLAGS_RST};
			st_nxt.enables  = {4'h0, `PIEF_EN_RST};
			st_nxt.polarity = `PIEF_POL_RST;
			st_nxt.latch    = `PIEF_LATCH_RST;
			st_nxt.mask     = `PIEF_MASK_RST;
			st_nxt.irq      = 1'b0;
			st_nxt.x_valid  = 1'b0;
			st_nxt.pready   = 1'b0;
			st_nxt.prdata   = 32'h0000_0000;
			st_nxt.pslverr  = 1'b0;
		end
	end

	// single register bank
	always_ff @(posedge clk_sys_i) begin
		st_r <= st_nxt;
	end

	// pullup per pin from latch bit; outputs straight from flops
	assign pullup_en_o = st_r.latch;
	assign irq_o       = st_r.irq;
	assign pready_o    = st_r.pready;
	assign prdata_o    = st_r.prdata;
	assign pslverr_o   = st_r.pslverr;

	// bus contract as the checks below see it:
	//   a transfer is taken on the first access edge, psel and penable high
	//   with pready_o still low; pready_o answers one clock later and drops
	//   after one clock, so every transfer costs exactly one wait state.
	//   prdata_o and pslverr_o stand only while pready_o stands; between
	//   answers both sit at zero so a sloppy master sees no stale data.
	//   an unmapped or misaligned address answers with pslverr_o and has
	//   no effect; writes to the two pin registers are ignored silently.
	// pin contract:
	//   a pin level is accepted once sync stages 2 and 3 agree, so a pulse
	//   shorter than two clocks may be lost; that is the price of filtering.
	//   a chosen edge sets its flag one clock after acceptance and the
	//   request follows in the same clock as the flag.
	// interrupt contract:
	//   flags are sticky; software writes a one to set and a zero to clear,
	//   and an edge in the clearing cycle wins so no event is lost.
	//   irq_o is a level: mask and any flag with its enable.

	// a set flag 0 survives every cycle without a write to the low flag register
	flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(st_r.flags[0] && !(acc_w && pwrite_i && idx_w == `PIEF_IDX_FLAGS_LOW))
		|=> st_r.flags[0]) else $error("flag dropped");

	// no flag of any source falls while no write is under way
	no_auto_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!(acc_w && pwrite_i) |=> ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags)))
		else $error("flag cleared by hardware");

	// accepted rise with rising polarity must set the flag
	rise_sets_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(st_r.x_valid && !st_r.polarity[0] && !st_r.x_lvl[0] && st_r.x_s2[0]
		&& st_r.x_s3[0] && $stable(st_r.polarity)) |=> st_r.flags[0])
		else $error("rise missed");

	// accepted fall with falling polarity must set the flag
	fall_sets_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(st_r.x_valid && st_r.polarity[1] && st_r.x_lvl[1] && !st_r.x_s2[1]
		&& !st_r.x_s3[1] && $stable(st_r.polarity)) |=> st_r.flags[1])
		else $error("fall missed");

	// a software write of one sets the flag like an edge would
	soft_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(acc_w && !pready_o && pwrite_i && pstrb_i[0] && aligned_w
		&& idx_w == `PIEF_IDX_FLAGS_LOW && pwdata_i[2]) |=> st_r.flags[2])
		else $error("software set lost");

	// request is the level of mask and any enabled flag
	irq_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		irq_o == (st_r.mask && |(st_r.flags & st_r.enables)))
		else $error("irq mismatch");

	// all enables off blocks the request whatever the flags
	irq_blocked_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(st_r.enables == 12'h000) |-> !irq_o) else $error("irq not blocked");

	// the global mask off blocks the request as well
	mask_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!st_r.mask |-> !irq_o) else $error("irq through mask");

	// an enable write lands one clock after it is taken
	en_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(acc_w && !pready_o && pwrite_i && pstrb_i[0] && aligned_w
		&& idx_w == `PIEF_IDX_EN_LOW) |=> st_r.enables[7:0] == $past(pwdata_i[7:0]))
		else $error("enable write lost");

	// port 1 answers never show the reserved bit or anything above
	high_bits_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(pready_o && prdata_o[31:7] != 25'h0000000) |->
		!$past(idx_w == `PIEF_IDX_PORT1)) else $error("reserved bit set");

	// port 0 answers carry the accepted pin levels
	port0_rd_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(pready_o && !pslverr_o && $past(idx_w == `PIEF_IDX_PORT0)) |->
		prdata_o == {24'h000000, $past(st_r.p0_lvl)}) else $error("port0 read wrong");

	// port 1 answers carry the accepted levels below a zero top bit
	port1_rd_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(pready_o && !pslverr_o && $past(idx_w == `PIEF_IDX_PORT1)) |->
		prdata_o == {25'h0000000, $past(st_r.p1_lvl)}) else $error("port1 read wrong");

	// upper flag register reads zero above its four sources
	flags_high_rd_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(pready_o && $past(idx_w == `PIEF_IDX_FLAGS_HIGH)) |->
		prdata_o[31:4] == 28'h0000000) else $error("flag high bits set");

	// upper enable register reads zero above its four sources
	en_high_rd_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(pready_o && $past(idx_w == `PIEF_IDX_EN_HIGH)) |->
		prdata_o[31:4] == 28'h0000000) else $error("enable high bits set");

	// reset_i clears flags, enables and the request
	reset_clear_a: assert property (@(posedge clk_sys_i)
		reset_i |=> (st_r.flags == 12'h000 && st_r.enables == 12'h000 && !irq_o))
		else $error("reset left state");

	// a steady pin reaches the port 0 register within four clocks
	port0_follow_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(port0_pins_i == 8'hA5)[*4] |=> st_r.p0_lvl == 8'hA5)
		else $error("port0 stale");

	// pullups come back on after reset
	pullup_a: assert property (@(posedge clk_sys_i)
		reset_i |=> pullup_en_o == `PIEF_LATCH_RST)
		else $error("pullup reset wrong");

	// a latch write moves the pullups one clock later
	latch_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(acc_w && !pready_o && pwrite_i && pstrb_i[1:0] == 2'h3 && aligned_w
		&& idx_w == `PIEF_IDX_LATCH) |=> pullup_en_o == $past(pwdata_i[14:0]))
		else $error("pullup write lost");

	// every taken transfer is answered after one wait state
	ready_one_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(psel_i && penable_i && !pready_o) |=> pready_o) else $error("no answer");

	// the answer stands for exactly one clock
	ready_pulse_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		pready_o |=> !pready_o) else $error("answer too long");

	// between answers the data and error lines rest at zero
	idle_quiet_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!pready_o |-> (prdata_o == 32'h0000_0000 && !pslverr_o))
		else $error("idle bus not quiet");

	// an error answer carries no data
	err_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		pslverr_o |-> prdata_o == 32'h0000_0000) else $error("error with data");

	// a misaligned address is refused
	misalign_err_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(acc_w && !pready_o && !aligned_w) |=> pslverr_o)
		else $error("misaligned accepted");

	// main scenarios reached by the bench
	irq_seen_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(irq_o));
	flag_clr_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) $fell(st_r.flags[0]));
	err_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) pslverr_o);
	high_src_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(st_r.flags[11]));

endmodule : pief_top
`default_nettype wire

// [sim/pief_pins.sv]
// pief_pins.sv: model of what drives the port and interrupt pins.
// assumes: the bench sets wanted levels; pins move just after clk edges.
`timescale 1ns/1ps
`default_nettype none
module pief_pins (
	input  wire logic        clk_sys_i,
	input  wire logic [7:0]  p0_want_i,
	input  wire logic [6:0]  p1_want_i,
	input  wire logic [11:0] x_want_i,
	input  wire logic        float_i,
	input  wire logic [14:0] pullup_en_i,
	output logic      [7:0]  port0_o,
	output logic      [6:0]  port1_o,
	output logic      [11:0] x_o
);
	// a released port 0 pin rises on its weak pullup, otherwise it wanders; port 1 and interrupt pins ignore float_i
	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < 8; i++) begin
			port0_o[i] <= !float_i ? p0_want_i[i] : pullup_en_i[i] ? 1'b1 : ~port0_o[i];
		end
		port1_o <= p1_want_i;
		x_o     <= x_want_i;
	end
endmodule : pief_pins
`default_nettype wire

// [sim/test_port_input_ext_interrupt_flags.sv]
// test_port_input_ext_interrupt_flags.sv: self-checking bench, APB master.
// assumes: pief_top and pief_pins compiled first; 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_port_input_ext_interrupt_flags;
	logic        clk_sys_i = 1'b0;
	logic        reset_i   = 1'b1;
	logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwd = 32'h0, prd, r;
	logic        prdy, perr, irq, e, flt = 1'b0;
	logic [7:0]  p0, p0w = 8'h00;
	logic [6:0]  p1, p1w = 7'h00;
	logic [11:0] x, xw = 12'h000, pol;
	logic [14:0] pu, lat;
	logic [7:0]  en, fl;
	logic [31:0] seed = 32'h0A20D6BD; // xorshift state, fixed start
	int          bad_count = 0, compares = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	pief_top pief_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
		.pstrb_i(4'hF), .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
		.port0_pins_i(p0), .port1_pins_i(p1), .ext_int_pins_i(x),
		.pullup_en_o(pu), .irq_o(irq));
	pief_pins pief_pins_i (.clk_sys_i(clk_sys_i), .p0_want_i(p0w), .p1_want_i(p1w),
		.x_want_i(xw), .float_i(flt), .pullup_en_i(pu), .port0_o(p0),
		.port1_o(p1), .x_o(x));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic final_report;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	// one transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel  <= 1'b1;
		pwr   <= w;
		paddr <= {2'b00, i, 2'b00};
		pwd   <= d;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (n >= 20) begin
			chk(0, 1, "no pready");
			final_report();
		end
	endtask : apb
	task automatic rd(input logic [7:0] i, input logic [31:0] x_exp, input string m);
		apb(1'b0, i, 32'h0);
		chk(r, x_exp, m);
	endtask : rd
	initial begin
		repeat (4) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		// reset values, then live pins
		for (int i = 4; i < 8; i++) rd(i, 0, "reset value");
		chk(pu, 15'h7FFF, "pullup reset");
		rd(8'h02, p0w, "port0 after reset");
		rd(8'h03, {25'h0, p1w}, "port1 after reset");
		apb(1'b1, 8'h02, 32'hFF);
		for (int k = 0; k < 6; k++) begin
			p0w <= 8'(rnd());
			p1w <= 7'(rnd());
			repeat (8) @(posedge clk_sys_i);
			rd(8'h02, p0w, "port0 pins");
			rd(8'h03, {25'h0, p1w}, "port1 pins");
		end
		apb(1'b0, 8'h3F, 32'h0);
		chk({r[30:0], e}, 1, "unmapped"); // unmapped refused
		// pullup control from latch bits; released pins with pullup on float up
		lat = 15'(rnd());
		apb(1'b1, 8'h0B, {17'h0, lat});
		chk(pu, lat, "pullup enables");
		flt <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		apb(1'b0, 8'h02, 32'h0);
		chk(r[7:0] & lat[7:0], lat[7:0], "pullup level");
		flt <= 1'b0;
		// chosen edge sets all flags, opposite edge sets none; enables off
		for (int k = 0; k < 3; k++) begin
			pol = 12'(rnd());
			apb(1'b1, 8'h0A, {20'h0, pol});
			xw <= pol;
			repeat (10) @(posedge clk_sys_i);
			apb(1'b1, 8'h04, 0);
			apb(1'b1, 8'h06, 0);
			xw <= ~pol;
			repeat (10) @(posedge clk_sys_i);
			rd(8'h04, 8'hFF, "edge flags low");
			rd(8'h06, 8'h0F, "edge flags high");
			chk(irq, 0, "irq while disabled");
			apb(1'b1, 8'h04, 0);
			apb(1'b1, 8'h06, 0);
			xw <= pol;
			repeat (10) @(posedge clk_sys_i);
			rd(8'h04, 0, "wrong edge low");
			rd(8'h06, 0, "wrong edge high");
		end
		apb(1'b1, 8'h07, 32'hFF);
		rd(8'h07, 8'h0F, "enable high");
		for (int k = 0; k < 4; k++) begin
			en = 8'(rnd());
			fl = (k == 0) ? 8'h01 : 8'(rnd());
			apb(1'b1, 8'h05, en);
			apb(1'b1, 8'h04, fl);
			repeat (20) @(posedge clk_sys_i);
			rd(8'h05, en, "enable low");
			rd(8'h04, fl, "flag sticks");
			chk(irq, |(fl & en), "irq level");
			apb(1'b1, 8'h04, 0);
			repeat (2) @(posedge clk_sys_i);
			chk(irq, 0, "irq after clear");
		end
		apb(1'b1, 8'h06, 32'hFF);
		repeat (2) @(posedge clk_sys_i);
		chk(irq, 1, "high source irq");
		apb(1'b1, 8'h06, 0);
		final_report();
	end
endmodule : test_port_input_ext_interrupt_flags
`default_nettype wire
